/* logic/lnb_fault_hiccup_tone_control.sv */
// Purpose: Hiccup timer, thermal shutdown, latched fault pin and tone selection of an LNB supply
// Assumes: 200 MHz clk, comparator and pin inputs asynchronous, APB register access
// Notes: Long counts are parameters so a simulation can shorten them
// Behaviour
// - Overcurrent lasting over 4 ms shuts converter down; retry after 128 ms.
// - Current limit chosen by resistor or by a software-written register.
// - Output off above 160 C, back on below 140 C.
// - Register bus and fault logic keep working during protection states.
// - Entering hiccup or thermal shutdown drives the fault pin low.
// - Fault pin stays low until a clearing action, even after recovery.
// - Without serial control, recycling the enable pin releases the fault pin.
// - With serial control, reading the flags releases the fault pin.
// - Tone may come from the external tone input.
// - Tone may come from the internal generator, switched by control logic.
// - Option four gives internal tone only while gate bit is set.
// - Source select one picks internal generator, zero picks external input.
// - Gate bit one lets the internal generator run ungated; zero gates it with the external input.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "lnb_consts.svh"

module lnb_fault_hiccup_tone_control #(
	parameter int OC_WINDOW_CYC = `LNB_OC_WINDOW_MS * `LNB_CLK_MHZ * 1000,
	parameter int HICCUP_OFF_CYC = `LNB_HICCUP_OFF_MS * `LNB_CLK_MHZ * 1000,
	parameter int TONE_HALF_CYC = (`LNB_CLK_MHZ * 1000000) / (2 * `LNB_TONE_HZ)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire lnb_pkg::addr_t paddr,
	input wire lnb_pkg::word_t pwdata,
	output lnb_pkg::word_t prdata,
	output logic pready,
	output logic pslverr,
	// Analog status inputs
	input wire logic overcurrent_in,
	input wire logic temp_above_high,
	input wire logic temp_below_low,
	// Enable pin and external tone input
	input wire logic enable_pin,
	input wire logic external_tone_input,
	// Open-drain fault pin, active low
	input wire logic fault_n_in,
	output logic fault_n_out,
	output logic fault_n_oe,
	// Regulator controls
	output logic converter_enable,
	output logic tone_out,
	output logic limit_by_resistor,
	output logic [1:0] current_limit_sel,
	// Interrupt
	output logic irq
);
	import lnb_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// ==========================================================
	// Address decode
	function automatic logic reg_hit(input addr_t a, input addr_t off);
		reg_hit = (a == off);
	endfunction

	wire hit_ctrl = reg_hit(paddr, `LNB_OFF_CTRL);
	wire hit_clim = reg_hit(paddr, `LNB_OFF_CLIM);
	wire hit_flags = reg_hit(paddr, `LNB_OFF_FLAGS);
	wire hit_ist = reg_hit(paddr, `LNB_OFF_IRQ_STAT);
	wire hit_ien = reg_hit(paddr, `LNB_OFF_IRQ_EN);
	wire hit_iclr = reg_hit(paddr, `LNB_OFF_IRQ_CLR);
	wire mapped = hit_ctrl | hit_clim | hit_flags | hit_ist | hit_ien | hit_iclr;
	wire apb_acc = psel & penable;
	wire apb_wr = apb_acc & pwrite & mapped;
	wire flags_rd = apb_acc & ~pwrite & hit_flags;

	// ==========================================================
	// Pin synchronisers
	logic [5:0] pins_s;

	pin_sync #(.W(6)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.async_in({fault_n_in, external_tone_input, temp_below_low, temp_above_high,
			overcurrent_in, enable_pin}),
		.level_out(pins_s)
	);

	wire en_s = pins_s[0];
	wire oc_s = pins_s[1];
	wire hot_s = pins_s[2];
	wire cool_s = pins_s[3];
	wire ext_s = pins_s[4];

	// ==========================================================
	// Registers
	logic [7:0] ctrl_r;
	logic [2:0] clim_r;
	logic [`LNB_IRQ_N-1:0] irq_st_r;
	logic [`LNB_IRQ_N-1:0] irq_en_r;
	logic [`LNB_IRQ_N-1:0] irq_ev;
	word_t prdata_r;

	wire serial_en = ctrl_r[`LNB_CTRL_SERIAL_EN];
	wire tone_source_select = ctrl_r[`LNB_CTRL_TONE_SRC];
	wire tone_gate_control = ctrl_r[`LNB_CTRL_TONE_GATE];

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			ctrl_r <= `LNB_CTRL_RESET;
			clim_r <= `LNB_CLIM_RESET;
			irq_en_r <= '0;
		end
		else
		begin
			if (apb_wr && hit_ctrl)
				ctrl_r <= pwdata[7:0];
			if (apb_wr && hit_clim)
				clim_r <= pwdata[2:0];
			if (apb_wr && hit_ien)
				irq_en_r <= pwdata[`LNB_IRQ_N-1:0];
		end
	end

	assign limit_by_resistor = clim_r[`LNB_CLIM_BY_RES];
	assign current_limit_sel = clim_r[`LNB_CLIM_SEL_HI:`LNB_CLIM_SEL_LO];

	// ==========================================================
	// Hiccup timer
	hiccup_state_e st_r;
	hiccup_state_e st_nxt;
	logic [`LNB_CNT_W-1:0] cnt_r;
	logic [`LNB_CNT_W-1:0] cnt_nxt;
	logic conv_req;

	assign conv_req = serial_en ? ctrl_r[`LNB_CTRL_OUT_EN] : en_s;

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			HC_RUN:
				if (oc_s)
					st_nxt = HC_LIMIT;
			HC_LIMIT:
				if (!oc_s)
					st_nxt = HC_RUN;
				else if (cnt_r == `LNB_CNT_W'(OC_WINDOW_CYC - 1))
					st_nxt = HC_OFF;
			HC_OFF:
				if (cnt_r == `LNB_CNT_W'(HICCUP_OFF_CYC - 1))
					st_nxt = HC_RUN;
			default:
				st_nxt = HC_RUN;
		endcase
	end

	// Counter restarts on every state change
	assign cnt_nxt = (st_nxt != st_r || st_r == HC_RUN) ? '0 : cnt_r + 1'b1;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_r <= HC_RUN;
			cnt_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	wire enter_off = (st_r == HC_LIMIT) && (st_nxt == HC_OFF);
	wire retry = (st_r == HC_OFF) && (st_nxt == HC_RUN);

	// ==========================================================
	// Thermal shutdown with hysteresis
	logic therm_r;
	logic therm_nxt;

	assign therm_nxt = hot_s | (therm_r & ~cool_s);
	wire therm_rise = ~therm_r & therm_nxt;
	wire therm_fall = therm_r & ~therm_nxt;

	// ==========================================================
	// Output enable and latched fault
	logic output_on_r;
	logic fault_r;
	logic en_d_r;
	logic ocf_r;
	logic otf_r;

	wire output_on = conv_req && (st_r != HC_OFF) && !therm_r;
	wire fault_set = enter_off | therm_rise;
	wire clr_en = ~serial_en & en_s & ~en_d_r;
	wire clr_rd = serial_en & flags_rd;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			therm_r <= 1'b0;
			output_on_r <= 1'b0;
			fault_r <= 1'b0;
			en_d_r <= 1'b0;
			ocf_r <= 1'b0;
			otf_r <= 1'b0;
		end
		else
		begin
			therm_r <= therm_nxt;
			output_on_r <= output_on;
			en_d_r <= en_s;
			// Set wins over either clear
			fault_r <= fault_set | (fault_r & ~(clr_en | clr_rd));
			ocf_r <= enter_off | (ocf_r & ~flags_rd);
			otf_r <= therm_rise | (otf_r & ~flags_rd);
		end
	end

	assign converter_enable = output_on_r;
	assign fault_n_out = 1'b0;
	assign fault_n_oe = fault_r;

	// ==========================================================
	// Tone generation and selection
	logic [`LNB_TONE_CNT_W-1:0] tcnt_r;
	logic int_tone_r;
	logic tone_r;

	wire tone_src = tone_source_select ? int_tone_r : ext_s;
	// Gate off with internal source uses the external input as gate
	wire tone_ok = tone_gate_control | ~tone_source_select | ext_s;
	wire tone_nxt = output_on & tone_src & tone_ok;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			tcnt_r <= '0;
			int_tone_r <= 1'b0;
			tone_r <= 1'b0;
		end
		else
		begin
			if (tcnt_r == `LNB_TONE_CNT_W'(TONE_HALF_CYC - 1))
			begin
				tcnt_r <= '0;
				int_tone_r <= ~int_tone_r;
			end
			else
				tcnt_r <= tcnt_r + 1'b1;
			tone_r <= tone_nxt;
		end
	end

	assign tone_out = tone_r;

	// ==========================================================
	// Interrupts
	assign irq_ev[`LNB_IRQ_HICCUP] = enter_off;
	assign irq_ev[`LNB_IRQ_THERM_OFF] = therm_rise;
	assign irq_ev[`LNB_IRQ_THERM_ON] = therm_fall;
	assign irq_ev[`LNB_IRQ_RETRY] = retry;

	genvar gi;
	generate
		for (gi = 0; gi < `LNB_IRQ_N; gi = gi + 1)
		begin : g_irq
			always_ff @(posedge clk)
			begin
				if (!rst_b)
					irq_st_r[gi] <= 1'b0;
				else
					irq_st_r[gi] <= irq_ev[gi] | (irq_st_r[gi] & ~(apb_wr & hit_iclr & pwdata[gi]));
			end
		end
	endgenerate

	assign irq = |(irq_st_r & irq_en_r);

	// ==========================================================
	// Read data, captured in the setup phase
	word_t rd_mux;

	assign rd_mux = hit_ctrl ? {24'h00_0000, ctrl_r} :
		hit_clim ? {29'h0000_0000, clim_r} :
		hit_flags ? {26'h000_0000, ~pins_s[5], fault_r, therm_r, st_r == HC_OFF, otf_r, ocf_r} :
		hit_ist ? {28'h000_0000, irq_st_r} :
		hit_ien ? {28'h000_0000, irq_en_r} : 32'h0000_0000;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			prdata_r <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata_r <= rd_mux;
	end

	assign prdata = prdata_r;
	assign pready = apb_acc;
	assign pslverr = apb_acc & ~mapped;

	// ==========================================================
	// Checks
	AST_HICCUP_ENTRY: assert property (
		st_r == HC_LIMIT && oc_s && cnt_r == `LNB_CNT_W'(OC_WINDOW_CYC - 1)
		|=> st_r == HC_OFF ##1 !converter_enable)
		else $error("hiccup not entered after overcurrent window");

	AST_HICCUP_RETRY: assert property (
		st_r == HC_OFF && cnt_r == `LNB_CNT_W'(HICCUP_OFF_CYC - 1) |=> st_r == HC_RUN)
		else $error("no restart after hiccup off time");

	AST_WINDOW_RESTART: assert property (
		st_r == HC_LIMIT && !oc_s |=> st_r == HC_RUN && cnt_r == '0)
		else $error("overcurrent window not restarted");

	AST_THERM_OFF: assert property (
		hot_s |=> ##1 !converter_enable)
		else $error("output not off in thermal shutdown");

	AST_THERM_HOLD: assert property (
		therm_r && !cool_s |=> therm_r)
		else $error("thermal shutdown left above low threshold");

	AST_FAULT_SET: assert property (
		fault_set |=> fault_n_oe && !fault_n_out)
		else $error("fault pin not driven low on protection entry");

	AST_FAULT_HOLD: assert property (
		fault_r && !clr_en && !clr_rd |=> fault_r)
		else $error("fault released without clearing action");

	AST_FAULT_EN_CLR: assert property (
		!serial_en && $rose(en_s) && !fault_set |=> !fault_n_oe)
		else $error("enable recycle did not release fault");

	AST_FAULT_RD_CLR: assert property (
		serial_en && flags_rd && !fault_set |=> !fault_n_oe)
		else $error("flag read did not release fault");

	AST_BUS_ALIVE: assert property (
		therm_r && psel && !penable && !pwrite && hit_flags |=> pready && prdata[`LNB_FLG_THERM])
		else $error("bus stalled during protection");

	AST_TONE_OFF: assert property (
		!output_on |=> !tone_out)
		else $error("tone active with output disabled");

	AST_TONE_OPT1: assert property (
		output_on && !tone_source_select && !tone_gate_control |=> tone_out == $past(ext_s))
		else $error("external tone not passed through");

	AST_TONE_OPT2: assert property (
		output_on && tone_source_select && !tone_gate_control
		|=> tone_out == ($past(int_tone_r) && $past(ext_s)))
		else $error("internal tone not gated by external input");

	AST_CLIM_WR: assert property (
		apb_wr && hit_clim |=> current_limit_sel == $past(pwdata[2:1]))
		else $error("current limit register not applied");

	COV_HICCUP: cover property (enter_off ##[1:1000] retry);
	COV_THERM: cover property (therm_rise ##[1:1000] therm_fall);
	COV_RD_CLR: cover property (fault_r && clr_rd);
	COV_TONE_INT: cover property (tone_source_select && tone_gate_control && tone_out);

endmodule

/* logic/lnb_consts.svh */
// Purpose: Offsets, field positions, reset values and timing figures of the LNB control block
// Assumes: 8-bit APB byte address, 32-bit data, one word per register
// Notes: Definitions only
`ifndef LNB_CONSTS_SVH
`define LNB_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define LNB_OFF_CTRL 8'h00
`define LNB_OFF_CLIM 8'h04
`define LNB_OFF_FLAGS 8'h08
`define LNB_OFF_IRQ_STAT 8'h0C
`define LNB_OFF_IRQ_EN 8'h10
`define LNB_OFF_IRQ_CLR 8'h14

// ==========================================================
// Control register fields
`define LNB_CTRL_OUT_EN 3
`define LNB_CTRL_TONE_SRC 4
`define LNB_CTRL_TONE_GATE 5
`define LNB_CTRL_SERIAL_EN 7
`define LNB_CTRL_RESET 8'h08

// ==========================================================
// Current limit register fields
`define LNB_CLIM_BY_RES 0
`define LNB_CLIM_SEL_LO 1
`define LNB_CLIM_SEL_HI 2
`define LNB_CLIM_RESET 3'h1

// ==========================================================
// Flag register fields
`define LNB_FLG_OC 0
`define LNB_FLG_OT 1
`define LNB_FLG_HICCUP 2
`define LNB_FLG_THERM 3
`define LNB_FLG_FAULT 4
`define LNB_FLG_PIN 5

// ==========================================================
// Interrupt events
`define LNB_IRQ_N 4
`define LNB_IRQ_HICCUP 0
`define LNB_IRQ_THERM_OFF 1
`define LNB_IRQ_THERM_ON 2
`define LNB_IRQ_RETRY 3

// ==========================================================
// Timing figures
`define LNB_CLK_MHZ 200
`define LNB_OC_WINDOW_MS 4
`define LNB_HICCUP_OFF_MS 128
`define LNB_TONE_HZ 22000
`define LNB_CNT_W 25
`define LNB_TONE_CNT_W 13

`endif

/* logic/lnb_pkg.sv */
// Purpose: Types shared by the LNB control block
// Assumes: Nothing beyond the constants header
// Notes: Binary state codes written out
package lnb_pkg;

	typedef enum logic [1:0]
	{
		HC_RUN = 2'b00,
		HC_LIMIT = 2'b01,
		HC_OFF = 2'b10
	} hiccup_state_e;

	typedef logic [31:0] word_t;
	typedef logic [7:0] addr_t;

endpackage

/* logic/pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for asynchronous pins
// Assumes: Inputs are asynchronous to clk
// Notes: A change counts once the second and third stages agree
`timescale 1ns/1ps

module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Pins and filtered levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level_out
);

	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;
	logic [W-1:0] level_r;

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (!rst_b)
				begin
					ff1_r[i] <= 1'b0;
					ff2_r[i] <= 1'b0;
					ff3_r[i] <= 1'b0;
					level_r[i] <= 1'b0;
				end
				else
				begin
					ff1_r[i] <= async_in[i];
					ff2_r[i] <= ff1_r[i];
					ff3_r[i] <= ff2_r[i];
					if (ff2_r[i] == ff3_r[i])
						level_r[i] <= ff3_r[i];
				end
			end
		end
	endgenerate

	assign level_out = level_r;

endmodule

/* sim/lnb_load_model.sv */
// Purpose: Regulator load and pulled-up fault wire facing the control block
// Assumes: A shorted output draws overcurrent only while the converter runs
// Notes: Behavioural, no clock
`timescale 1ns/1ps

module lnb_load_model (
	// Stimulus
	input wire logic short_cmd,
	// Block outputs
	input wire logic converter_enable,
	input wire logic fault_n_out,
	input wire logic fault_n_oe,
	// Back to the block
	output logic overcurrent_in,
	output logic fault_wire
);
	// ==========
	// Load
	assign overcurrent_in = short_cmd & converter_enable;
	// ==========
	// Open-drain wire, pull-up when released
	assign fault_wire = fault_n_oe ? fault_n_out : 1'b1;
endmodule

/* sim/lnb_fault_hiccup_tone_control_bench.sv */
// Purpose: Self-checking bench of the LNB control block
// Assumes: Shortened counts 8, 20 and 4 cycles
// Notes: Tone options as table rows, protection cases by hand
`timescale 1ns/1ps

module lnb_fault_hiccup_tone_control_bench;
	import lnb_pkg::*;
	logic clk = 0;
	logic rst_b = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	addr_t paddr = 8'h00;
	word_t pwdata = 32'h0000_0000;
	word_t prdata;
	word_t rd;
	logic pready, pslverr, err, oc, fault_n_out, fault_n_oe, fault_wire;
	logic ce, tone, lim_res, irq, last;
	logic hot = 0;
	logic cool = 1;
	logic en_pin = 1;
	logic ext = 0;
	logic short_cmd = 0;
	logic [1:0] lim_sel;
	int fails = 0;
	int samples_checked = 0;
	int waited, tog;
	// Control value, external input, expected: 0/1 level, 2 running tone
	logic [10:0] rows [7] = '{{8'h88, 1'b1, 2'd1}, {8'h88, 1'b0, 2'd0}, {8'h98, 1'b1, 2'd2},
		{8'h98, 1'b0, 2'd0}, {8'hA8, 1'b1, 2'd1}, {8'hB8, 1'b0, 2'd2}, {8'hB0, 1'b1, 2'd0}};

	always #2.5 clk = ~clk;

	lnb_fault_hiccup_tone_control #(.OC_WINDOW_CYC(8), .HICCUP_OFF_CYC(20), .TONE_HALF_CYC(4))
	u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.overcurrent_in(oc), .temp_above_high(hot), .temp_below_low(cool),
		.enable_pin(en_pin), .external_tone_input(ext), .fault_n_in(fault_wire),
		.fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe), .converter_enable(ce),
		.tone_out(tone), .limit_by_resistor(lim_res), .current_limit_sel(lim_sel), .irq(irq));

	lnb_load_model u_load (.short_cmd(short_cmd), .converter_enable(ce),
		.fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe), .overcurrent_in(oc),
		.fault_wire(fault_wire));

	// ==========
	// Shared tasks
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input addr_t a, input word_t d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50)
		begin
			fails++;
			print_verdict();
		end
	endtask

	// Waits for the converter (sel 0) or the fault wire (sel 1) to reach v
	task automatic wait_for(input logic sel, input logic v);
		waited = 0;
		while ((sel ? fault_wire : ce) !== v && waited < 100)
		begin
			@(posedge clk);
			waited++;
		end
		if (waited >= 100)
		begin
			fails++;
			print_verdict();
		end
	endtask

	// ==========
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		apb(0, 8'h00, 0);
		chk("ctrl_reset", rd, 32'h0000_0008);
		apb(0, 8'h04, 0);
		chk("clim_reset", rd, 32'h0000_0001);
		apb(0, 8'h18, 0);
		chk("unmapped_error", err, 1);
		apb(1, 8'h04, 32'h0000_0006);
		@(posedge clk);
		chk("current_limit", {lim_res, lim_sel}, 3'b011);
		foreach (rows[i])
		begin
			apb(1, 8'h00, {24'h0, rows[i][10:3]});
			ext <= rows[i][2];
			repeat (12) @(posedge clk);
			tog = 0;
			last = tone;
			repeat (24)
			begin
				@(posedge clk);
				if (tone !== last)
					tog++;
				last = tone;
			end
			if (rows[i][1:0] == 2'd2)
				chk("tone_running", tog > 2, 1);
			else
				chk("tone_level", {tog != 0, tone}, {1'b0, rows[i][0]});
		end
		// Hiccup under serial control
		apb(1, 8'h00, 32'h0000_0088);
		apb(1, 8'h10, 32'h0000_0001);
		wait_for(0, 1);
		short_cmd <= 1'b1;
		repeat (6) @(posedge clk);
		short_cmd <= 1'b0;
		repeat (20) @(posedge clk);
		chk("short_glitch", ce, 1);
		short_cmd <= 1'b1;
		wait_for(0, 0);
		chk("oc_window", waited > 8, 1);
		short_cmd <= 1'b0;
		wait_for(0, 1);
		chk("hiccup_off", waited >= 20 && waited <= 21, 1);
		chk("fault_held", fault_wire, 0);
		chk("irq_raised", irq, 1);
		apb(1, 8'h10, 0);
		@(posedge clk);
		chk("irq_masked", irq, 0);
		apb(1, 8'h14, 32'h0000_000F);
		apb(1, 8'h10, 32'h0000_000F);
		@(posedge clk);
		chk("irq_cleared", irq, 0);
		apb(0, 8'h08, 0);
		chk("flags_hiccup", {rd[5:4], rd[0]}, 3'b111);
		wait_for(1, 1);
		apb(0, 8'h08, 0);
		chk("oc_flag_cleared", rd[0], 0);
		// Thermal shutdown under pin control
		apb(1, 8'h00, 32'h0000_0008);
		hot <= 1'b1;
		cool <= 1'b0;
		wait_for(0, 0);
		wait_for(1, 0);
		hot <= 1'b0;
		repeat (20) @(posedge clk);
		chk("hysteresis", ce, 0);
		apb(0, 8'h08, 0);
		chk("flags_thermal", rd[3], 1);
		repeat (10) @(posedge clk);
		chk("read_no_release", fault_wire, 0);
		cool <= 1'b1;
		wait_for(0, 1);
		chk("fault_after_cool", fault_wire, 0);
		en_pin <= 1'b0;
		wait_for(0, 0);
		en_pin <= 1'b1;
		wait_for(1, 1);
		// Reset in mid-run: outputs, limit and interrupt return to reset values
		apb(1, 8'h04, 32'h0000_0000);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		chk("reset_outputs", {ce, tone, irq, fault_n_oe, lim_res, lim_sel}, 7'h04);
		rst_b <= 1'b1;
		apb(0, 8'h04, 0);
		chk("clim_after_reset", rd, 32'h0000_0001);
		wait_for(0, 1);
		print_verdict();
	end
endmodule
